//--- rtl/pam_monitor.sv
`timescale 1ns/10ps
// What this block does
// - RTC and keyboard ports never count as PCI.
// - Port activity comes only from observed PCI cycles.
// - Forward hitting cycles to ISA when enabled.
// - ISA devices need ranges and forwarding enabled.
// - External PCI IDE cycles raise no events.
// - Software may use IRQs for standby reload.
// - Software swaps controllers to sense IDE idleness.
// - Timer expiry first means external IDE idle.
// - Trap first means external IDE busy.
// - Trap internal IDE, then swap and restart.
// - Monitor 0: primary ports, group A, standby+slow.
// - Monitor 1: primary plus input five, all.
// - Monitor 2: secondary ports, input six, all.
// - Monitor 3: secondary, input zero, software count.
// - Audio decodes MIDI, game and FM windows.
// - Audio decodes four sound card windows.
// - Audio codecs, DMA 0,1,3,5,6,7, input thirteen.
// - Floppy ports, DMA two, input fourteen, all.
// - Enabled trap hit sets sticky trap status.
// - Idle status belongs to timers outside here.
// - Each input has selectable assertion polarity.
module pam_monitor
    import pam_pkg::*;
#(
    parameter int unsigned NDEV = PAM_NDEV
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    pam_if.dev link,
    input wire logic [pam_pkg::PAM_NDEV-1:0] range_en,
    input wire logic [pam_pkg::PAM_NDEV-1:0] dack_en,
    input wire logic [pam_pkg::PAM_NDEV-1:0] gpi_en,
    input wire logic [pam_pkg::PAM_NDEV-1:0] gpi_pol_high,
    input wire logic [pam_pkg::PAM_NDEV-1:0] idle_rld_en,
    input wire logic [pam_pkg::PAM_NDEV-1:0] glb_rld_en,
    input wire logic [pam_pkg::PAM_NDEV-1:0] burst_rld_en,
    input wire logic [pam_pkg::PAM_NDEV-1:0] burst_sel_fast,
    input wire logic [pam_pkg::PAM_NDEV-1:0] trap_en,
    input wire logic [pam_pkg::PAM_NDEV-1:0] isa_fwd_en,
    input wire logic [pam_pkg::PAM_NDEV-1:0] drive_active,
    input wire logic [pam_pkg::PAM_NDEV-1:0] trap_sts_clr
);
    import pam_pkg::*;

    // The per-monitor decode below is written out for six monitors only.
    if (NDEV != PAM_NDEV) begin : g_bad_ndev
        $error("pam_monitor serves exactly six device monitors");
    end

    function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [2:0] rld_caps(input int unsigned d);
        unique case (d)
            0: rld_caps = PAM_RLD_DEV0;
            1: rld_caps = PAM_RLD_DEV1;
            2: rld_caps = PAM_RLD_DEV2;
            3: rld_caps = PAM_RLD_DEV3;
            4: rld_caps = PAM_RLD_DEV4;
            default: rld_caps = PAM_RLD_DEV5;
        endcase
    endfunction

    // Side-band pins come from outside this clock, so they pass two flops.
    logic [PAM_NGPI-1:0] gpi_s1_r, gpi_s2_r;
    logic [PAM_NDMA-1:0] dack_s1_r, dack_s2_r;
    logic [1:0] ide_s1_r, ide_s2_r;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            gpi_s1_r <= '0;
            gpi_s2_r <= '0;
            dack_s1_r <= '1;
            dack_s2_r <= '1;
            ide_s1_r <= 2'h3;
            ide_s2_r <= 2'h3;
        end else if (clk_en) begin
            gpi_s1_r <= link.gpi;
            gpi_s2_r <= gpi_s1_r;
            dack_s1_r <= link.isa_dma_ack_channel_n;
            dack_s2_r <= dack_s1_r;
            ide_s1_r <= {link.secondary_ide_dma_ack_n, link.primary_ide_dma_ack_n};
            ide_s2_r <= ide_s1_r;
        end
    end

    logic [15:0] a;
    logic cyc_ok;
    logic hit_pri, hit_sec, hit_audio, hit_fdd;
    assign a = link.io_addr;
    // only observed PCI cycles, never RTC/keyboard, never external PCI IDE.
    assign cyc_ok = link.io_valid && !link.io_on_pci_ide
        && a != PAM_KBC_DATA && a != PAM_KBC_CMD && !in_rng(a, PAM_RTC_LO, PAM_RTC_HI);
    assign hit_pri = in_rng(a, PAM_PRI_LO, PAM_PRI_HI) || a == PAM_PRI_CTL;
    assign hit_sec = in_rng(a, PAM_SEC_LO, PAM_SEC_HI) || a == PAM_SEC_CTL;
    assign hit_audio = ((a & PAM_MIDI_MASK) == PAM_MIDI_LO && a <= PAM_MIDI_HI)
        || in_rng(a, PAM_GAME_LO, PAM_GAME_HI) || in_rng(a, PAM_FM_LO, PAM_FM_HI)
        || in_rng(a, PAM_SND0_LO, PAM_SND0_HI) || in_rng(a, PAM_SND1_LO, PAM_SND1_HI)
        || in_rng(a, PAM_SND2_LO, PAM_SND2_HI) || in_rng(a, PAM_SND3_LO, PAM_SND3_HI)
        || in_rng(a, PAM_COD0_LO, PAM_COD0_HI) || in_rng(a, PAM_COD1_LO, PAM_COD1_HI)
        || in_rng(a, PAM_COD2_LO, PAM_COD2_HI) || in_rng(a, PAM_COD3_LO, PAM_COD3_HI);
    assign hit_fdd = in_rng(a, PAM_FDD0_LO, PAM_FDD0_HI) || in_rng(a, PAM_FDD1_LO, PAM_FDD1_HI)
        || a == PAM_FDD_CTL;

    logic [NDEV-1:0] acc_hit, dack_lvl, gpi_raw, act_lvl, act_prev_r, act_rise;
    // Drive selection gates the IDE monitors' port hits and DMA acknowledges, not their inputs; the others ignore drive_active.
    assign acc_hit[0] = cyc_ok && hit_pri && range_en[0] && drive_active[0];
    assign acc_hit[1] = cyc_ok && hit_pri && range_en[1] && drive_active[1];
    assign acc_hit[2] = cyc_ok && hit_sec && range_en[2] && drive_active[2];
    assign acc_hit[3] = cyc_ok && hit_sec && range_en[3] && drive_active[3];
    assign acc_hit[4] = cyc_ok && hit_audio && range_en[4];
    assign acc_hit[5] = cyc_ok && hit_fdd && range_en[5];

    assign dack_lvl[0] = !ide_s2_r[0] && drive_active[0];
    assign dack_lvl[1] = !ide_s2_r[0] && drive_active[1];
    assign dack_lvl[2] = !ide_s2_r[1] && drive_active[2];
    assign dack_lvl[3] = !ide_s2_r[1] && drive_active[3];
    assign dack_lvl[4] = |(~dack_s2_r & PAM_AUDIO_DMA);
    assign dack_lvl[5] = !dack_s2_r[PAM_FDD_DMA_CH];

    assign gpi_raw[0] = 1'b0; // monitor 0 has no input.
    assign gpi_raw[1] = gpi_s2_r[PAM_GPI_DEV1];
    assign gpi_raw[2] = gpi_s2_r[PAM_GPI_DEV2];
    assign gpi_raw[3] = gpi_s2_r[PAM_GPI_DEV3];
    assign gpi_raw[4] = gpi_s2_r[PAM_GPI_DEV4];
    assign gpi_raw[5] = gpi_s2_r[PAM_GPI_DEV5];

    // Capabilities are looked up per monitor so the reload logic can index their bits.
    logic [NDEV-1:0][2:0] caps;
    genvar d;
    generate
        for (d = 0; d < NDEV; d++) begin : g_lvl
            assign caps[d] = rld_caps(d);
            assign act_lvl[d] = (dack_en[d] && dack_lvl[d])
                || (gpi_en[d] && d != 0 && (gpi_raw[d] == gpi_pol_high[d]));
        end
    endgenerate

    // Held levels count once at assertion so each acknowledge gives one pulse.
    // Starting from all ones hides levels left on the freshly reset synchronisers,
    // so the release of reset gives no false pulse.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            act_prev_r <= '1;
        end else if (clk_en) begin
            act_prev_r <= act_lvl;
        end
    end
    assign act_rise = act_lvl & ~act_prev_r;

    logic [NDEV-1:0] evt;
    logic [2:0] trl_nxt;
    assign evt = acc_hit | act_rise;
    always_comb begin
        trl_nxt = 3'h0;
        for (int unsigned i = 0; i < NDEV; i++) begin
            if (evt[i] && glb_rld_en[i] && caps[i][PAM_RLD_GLB]) begin
                trl_nxt[PAM_RLD_GLB] = 1'b1;
            end
            if (evt[i] && burst_rld_en[i] && burst_sel_fast[i] && caps[i][PAM_RLD_FAST]) begin
                trl_nxt[PAM_RLD_FAST] = 1'b1;
            end
            if (evt[i] && burst_rld_en[i] && !burst_sel_fast[i] && caps[i][PAM_RLD_SLOW]) begin
                trl_nxt[PAM_RLD_SLOW] = 1'b1;
            end
        end
    end

    // every event output lasts exactly one enabled cycle.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            link.idle_reload <= PAM_RST_ZERO6;
            link.timer_reload <= 3'h0;
            link.trap_pulse <= PAM_RST_ZERO6;
            link.forward_isa <= 1'b0;
        end else if (clk_en) begin
            link.idle_reload <= evt & idle_rld_en;
            link.timer_reload <= trl_nxt;
            link.trap_pulse <= acc_hit & trap_en;
            link.forward_isa <= |(acc_hit & isa_fwd_en);
        end
    end

    // set wins over a clear in the same cycle.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            link.trap_sts <= PAM_RST_ZERO6;
        end else if (clk_en) begin
            link.trap_sts <= (link.trap_sts & ~trap_sts_clr) | (acc_hit & trap_en);
        end
    end

    // fixed count group per monitor, for the idle timers outside.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < PAM_NDEV; i++) begin
                link.count_group_sel[i] <= 2'h0;
            end
        end else if (clk_en) begin
            link.count_group_sel[0] <= PAM_GRP_A;
            link.count_group_sel[1] <= PAM_GRP_A;
            link.count_group_sel[2] <= PAM_GRP_A;
            link.count_group_sel[3] <= PAM_GRP_SW;
            link.count_group_sel[4] <= PAM_GRP_B;
            link.count_group_sel[5] <= PAM_GRP_B;
        end
    end
endmodule

//--- rtl/pam_pkg.sv
package pam_pkg;
    localparam int unsigned PAM_NDEV = 6;
    localparam int unsigned PAM_AW = 16;
    localparam int unsigned PAM_NDMA = 8;
    localparam int unsigned PAM_NGPI = 22;

    // Device indices.
    localparam int unsigned PAM_DEV_PRI0 = 0;
    localparam int unsigned PAM_DEV_PRI1 = 1;
    localparam int unsigned PAM_DEV_SEC0 = 2;
    localparam int unsigned PAM_DEV_SEC1 = 3;
    localparam int unsigned PAM_DEV_AUDIO = 4;
    localparam int unsigned PAM_DEV_FLOPPY = 5;

    // Count group selectors.
    typedef enum logic [1:0] {
        PAM_GRP_A,
        PAM_GRP_B,
        PAM_GRP_SW
    } pam_grp_e;

    // Address windows as base and last address.
    localparam logic [15:0] PAM_PRI_LO = 16'h01f0;
    localparam logic [15:0] PAM_PRI_HI = 16'h01f7;
    localparam logic [15:0] PAM_PRI_CTL = 16'h03f6;
    localparam logic [15:0] PAM_SEC_LO = 16'h0170;
    localparam logic [15:0] PAM_SEC_HI = 16'h0177;
    localparam logic [15:0] PAM_SEC_CTL = 16'h0376;
    localparam logic [15:0] PAM_MIDI_LO = 16'h0300;
    localparam logic [15:0] PAM_MIDI_HI = 16'h0333;
    localparam logic [15:0] PAM_GAME_LO = 16'h0200;
    localparam logic [15:0] PAM_GAME_HI = 16'h0207;
    localparam logic [15:0] PAM_FM_LO = 16'h0388;
    localparam logic [15:0] PAM_FM_HI = 16'h038b;
    localparam logic [15:0] PAM_SND0_LO = 16'h0220;
    localparam logic [15:0] PAM_SND0_HI = 16'h0233;
    localparam logic [15:0] PAM_SND1_LO = 16'h0240;
    localparam logic [15:0] PAM_SND1_HI = 16'h0253;
    localparam logic [15:0] PAM_SND2_LO = 16'h0260;
    localparam logic [15:0] PAM_SND2_HI = 16'h0273;
    localparam logic [15:0] PAM_SND3_LO = 16'h0280;
    localparam logic [15:0] PAM_SND3_HI = 16'h0293;
    localparam logic [15:0] PAM_COD0_LO = 16'h0530;
    localparam logic [15:0] PAM_COD0_HI = 16'h0537;
    localparam logic [15:0] PAM_COD1_LO = 16'h0604;
    localparam logic [15:0] PAM_COD1_HI = 16'h060b;
    localparam logic [15:0] PAM_COD2_LO = 16'h0e80;
    localparam logic [15:0] PAM_COD2_HI = 16'h0e87;
    localparam logic [15:0] PAM_COD3_LO = 16'h0f40;
    localparam logic [15:0] PAM_COD3_HI = 16'h0f47;
    localparam logic [15:0] PAM_FDD0_LO = 16'h03f0;
    localparam logic [15:0] PAM_FDD0_HI = 16'h03f5;
    localparam logic [15:0] PAM_FDD1_LO = 16'h0370;
    localparam logic [15:0] PAM_FDD1_HI = 16'h0375;
    localparam logic [15:0] PAM_FDD_CTL = 16'h03f7;
    // Real-time clock and keyboard controller ports, never treated as PCI-side.
    localparam logic [15:0] PAM_KBC_DATA = 16'h0060;
    localparam logic [15:0] PAM_KBC_CMD = 16'h0064;
    localparam logic [15:0] PAM_RTC_LO = 16'h0070;
    localparam logic [15:0] PAM_RTC_HI = 16'h0077;

    // Low two address bits ignored inside the MIDI windows; one window each 10h.
    localparam logic [15:0] PAM_MIDI_MASK = 16'hffcc;

    // DMA acknowledge channels.
    localparam logic [7:0] PAM_AUDIO_DMA = 8'heb;
    localparam int unsigned PAM_FDD_DMA_CH = 2;

    // General purpose input numbers.
    localparam int unsigned PAM_GPI_DEV1 = 5;
    localparam int unsigned PAM_GPI_DEV2 = 6;
    localparam int unsigned PAM_GPI_DEV3 = 0;
    localparam int unsigned PAM_GPI_DEV4 = 13;
    localparam int unsigned PAM_GPI_DEV5 = 14;

    // Per-device reload capability: bit 0 global standby, 1 fast burst, 2 slow burst.
    localparam logic [2:0] PAM_RLD_DEV0 = 3'h5;
    localparam logic [2:0] PAM_RLD_DEV1 = 3'h7;
    localparam logic [2:0] PAM_RLD_DEV2 = 3'h7;
    localparam logic [2:0] PAM_RLD_DEV3 = 3'h7;
    localparam logic [2:0] PAM_RLD_DEV4 = 3'h3;
    localparam logic [2:0] PAM_RLD_DEV5 = 3'h7;
    localparam int unsigned PAM_RLD_GLB = 0;
    localparam int unsigned PAM_RLD_FAST = 1;
    localparam int unsigned PAM_RLD_SLOW = 2;

    localparam logic [5:0] PAM_RST_ZERO6 = 6'h00;
endpackage

//--- rtl/pam_if.sv
`timescale 1ns/10ps
// The bus side drives observed I/O cycles and side-band activity; the monitor answers
// with event pulses and forwarding decisions.
interface pam_if;
    import pam_pkg::*;
    logic io_valid;
    logic [PAM_AW-1:0] io_addr;
    logic io_on_pci_ide;
    logic primary_ide_dma_ack_n;
    logic secondary_ide_dma_ack_n;
    logic [PAM_NDMA-1:0] isa_dma_ack_channel_n;
    logic [PAM_NGPI-1:0] gpi;
    logic [PAM_NDEV-1:0] idle_reload;
    logic [PAM_NDEV-1:0] trap_pulse;
    logic [2:0] timer_reload;
    logic forward_isa;
    logic [1:0] count_group_sel [PAM_NDEV];
    logic [PAM_NDEV-1:0] trap_sts;

    modport dev (
        input io_valid, io_addr, io_on_pci_ide, primary_ide_dma_ack_n,
        secondary_ide_dma_ack_n, isa_dma_ack_channel_n, gpi,
        output idle_reload, trap_pulse, timer_reload, forward_isa, count_group_sel, trap_sts
    );
    modport host (
        output io_valid, io_addr, io_on_pci_ide, primary_ide_dma_ack_n,
        secondary_ide_dma_ack_n, isa_dma_ack_channel_n, gpi,
        input idle_reload, trap_pulse, timer_reload, forward_isa, count_group_sel, trap_sts
    );
endinterface

//--- rtl/pam_host.sv
`timescale 1ns/10ps
// The bus side: registers each observed I/O cycle and side-band level onto the link.
module pam_host
    import pam_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    pam_if.host link,
    input wire logic cyc_valid,
    input wire logic [pam_pkg::PAM_AW-1:0] cyc_addr,
    input wire logic cyc_to_pci_ide,
    input wire logic pri_dack_n,
    input wire logic sec_dack_n,
    input wire logic [pam_pkg::PAM_NDMA-1:0] isa_dack_n,
    input wire logic [pam_pkg::PAM_NGPI-1:0] gpi_pins,
    output logic [pam_pkg::PAM_NDEV-1:0] trap_seen,
    output logic [2:0] reload_seen
);
    import pam_pkg::*;

    // cycles claimed by an external PCI IDE controller are flagged.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            link.io_valid <= 1'b0;
            link.io_addr <= '0;
            link.io_on_pci_ide <= 1'b0;
        end else if (clk_en) begin
            link.io_valid <= cyc_valid;
            link.io_addr <= cyc_addr;
            link.io_on_pci_ide <= cyc_to_pci_ide;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            link.primary_ide_dma_ack_n <= 1'b1;
            link.secondary_ide_dma_ack_n <= 1'b1;
            link.isa_dma_ack_channel_n <= '1;
            link.gpi <= '0;
        end else if (clk_en) begin
            link.primary_ide_dma_ack_n <= pri_dack_n;
            link.secondary_ide_dma_ack_n <= sec_dack_n;
            link.isa_dma_ack_channel_n <= isa_dack_n;
            link.gpi <= gpi_pins;
        end
    end

    // Sticky copies let software on this side poll what the monitor reported.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            trap_seen <= '0;
            reload_seen <= '0;
        end else if (clk_en) begin
            trap_seen <= trap_seen | link.trap_pulse;
            reload_seen <= reload_seen | link.timer_reload;
        end
    end
endmodule

//--- tb/pam_checker.sv
`timescale 1ns/10ps
module pam_checker
    import pam_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic io_valid,
    input wire logic [pam_pkg::PAM_AW-1:0] io_addr,
    input wire logic io_on_pci_ide,
    input wire logic primary_ide_dma_ack_n,
    input wire logic secondary_ide_dma_ack_n,
    input wire logic [pam_pkg::PAM_NDMA-1:0] isa_dma_ack_channel_n,
    input wire logic [pam_pkg::PAM_NGPI-1:0] gpi,
    input wire logic [pam_pkg::PAM_NDEV-1:0] idle_reload,
    input wire logic [pam_pkg::PAM_NDEV-1:0] trap_pulse,
    input wire logic [2:0] timer_reload,
    input wire logic forward_isa,
    input wire logic [1:0] count_group_sel [pam_pkg::PAM_NDEV],
    input wire logic [pam_pkg::PAM_NDEV-1:0] trap_sts
);
    import pam_pkg::*;
    logic [31:0] sb;
    logic [31:0] sb_q;
    logic [2:0] quiet_r;
    logic quiet;
    logic local_port;
    // Side-band edges reach the outputs a few cycles late, so event checks wait for calm lines.
    assign sb = {secondary_ide_dma_ack_n, primary_ide_dma_ack_n, isa_dma_ack_channel_n, gpi};
    assign quiet = quiet_r == 3'h7;
    assign local_port = io_addr == PAM_KBC_DATA || io_addr == PAM_KBC_CMD ||
        (io_addr >= PAM_RTC_LO && io_addr <= PAM_RTC_HI);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sb_q <= 32'h0;
            quiet_r <= 3'h0;
        end else begin
            sb_q <= sb;
            quiet_r <= (sb != sb_q) ? 3'h0 : (quiet ? quiet_r : quiet_r + 3'h1);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_none;
        idle_reload == 6'h00 && trap_pulse == 6'h00 && timer_reload == 3'h0 && !forward_isa;
    endsequence

    a_pci_ide_silent: assert property (io_valid && io_on_pci_ide && quiet |=> s_none)
        else $error("event raised for an external PCI IDE cycle");
    a_local_silent: assert property (io_valid && local_port && quiet |=> s_none)
        else $error("event raised for a clock or keyboard port");
    a_idle_no_event: assert property (!io_valid && quiet |=> s_none)
        else $error("event raised with no observed cycle");
    a_fwd_has_cause: assert property (forward_isa |-> $past(io_valid) && !$past(io_on_pci_ide))
        else $error("forward without a preceding eligible cycle");
    a_trap_sets_sts: assert property (trap_pulse != 6'h00 |-> (trap_sts & trap_pulse) == trap_pulse)
        else $error("trap pulse without trap status");
    a_group_codes: assert property ($past(nrst) && $past(nrst, 2) |->
        count_group_sel[0] == 2'h0 && count_group_sel[1] == 2'h0 && count_group_sel[2] == 2'h0 &&
        count_group_sel[3] == 2'h2 && count_group_sel[4] == 2'h1 && count_group_sel[5] == 2'h1)
        else $error("count group selection wrong");
    a_audio_no_slow: assert property (io_valid && !io_on_pci_ide && quiet &&
        io_addr >= PAM_FM_LO && io_addr <= PAM_FM_HI |=>
        !timer_reload[2] && trap_pulse[3:0] == 4'h0 && !trap_pulse[5])
        else $error("audio window gave slow reload or foreign trap");
    a_floppy_alone: assert property (io_valid && !io_on_pci_ide && quiet &&
        io_addr >= PAM_FDD0_LO && io_addr <= PAM_FDD0_HI |=>
        idle_reload[4:0] == 5'h00 && trap_pulse[4:0] == 5'h00)
        else $error("floppy window hit another monitor");
endmodule

//--- tb/tb_peripheral_activity_monitor.sv
`timescale 1ns/10ps
module tb_peripheral_activity_monitor;
    import pam_pkg::*;
    localparam logic [5:0] CAP_F = 6'h3e;
    localparam logic [5:0] CAP_S = 6'h2f;
    localparam logic [15:0] ADDRS [49] = '{16'h1f0, 16'h1f7, 16'h3f6, 16'h1f8, 16'h1ef,
        16'h170, 16'h177, 16'h376, 16'h178, 16'h300, 16'h303, 16'h310, 16'h313, 16'h320,
        16'h330, 16'h333, 16'h304, 16'h334, 16'h200, 16'h207, 16'h208, 16'h388, 16'h38b,
        16'h220, 16'h233, 16'h240, 16'h253, 16'h260, 16'h273, 16'h280, 16'h293, 16'h294,
        16'h530, 16'h537, 16'h604, 16'h60b, 16'he80, 16'he87, 16'hf40, 16'hf47, 16'h3f0,
        16'h3f5, 16'h3f7, 16'h370, 16'h375, 16'h060, 16'h064, 16'h070, 16'h077};
    localparam logic [5:0] DECS [49] = '{6'h03, 6'h03, 6'h03, 6'h00, 6'h00, 6'h0c, 6'h0c,
        6'h0c, 6'h00, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h00, 6'h00, 6'h10,
        6'h10, 6'h00, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10,
        6'h00, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h20, 6'h20, 6'h20,
        6'h20, 6'h20, 6'h00, 6'h00, 6'h00, 6'h00};
    localparam int SB_BIT [11] = '{5, 6, 0, 13, 14, 24, 22, 29, 26, 30, 31};
    localparam logic [5:0] SB_DEC [11] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h20, 6'h10,
        6'h10, 6'h00, 6'h03, 6'h0c};
    logic clock;
    logic nrst;
    logic cyc_valid;
    logic [15:0] cyc_addr;
    logic cyc_to_pci_ide;
    logic [31:0] sb;
    logic [5:0] range_en, dack_en, gpi_en, pol, idle_en, glb_en, brst_en, sel_fast;
    logic [5:0] trap_en, fwd_en, drv, sts_clr, sticky, all_tr, trap_seen;
    logic [2:0] reload_seen, all_rl;
    logic clk_en;
    int failures;
    int n_checks;

    pam_if lnk ();
    pam_host i_pam_host (.clock(clock), .nrst(nrst), .clk_en(clk_en), .link(lnk),
        .cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .cyc_to_pci_ide(cyc_to_pci_ide),
        .pri_dack_n(sb[30]), .sec_dack_n(sb[31]), .isa_dack_n(sb[29:22]),
        .gpi_pins(sb[21:0]), .trap_seen(trap_seen), .reload_seen(reload_seen));
    pam_monitor i_pam_monitor (.clock(clock), .nrst(nrst), .clk_en(clk_en), .link(lnk),
        .range_en(range_en), .dack_en(dack_en), .gpi_en(gpi_en), .gpi_pol_high(pol),
        .idle_rld_en(idle_en), .glb_rld_en(glb_en), .burst_rld_en(brst_en),
        .burst_sel_fast(sel_fast), .trap_en(trap_en), .isa_fwd_en(fwd_en),
        .drive_active(drv), .trap_sts_clr(sts_clr));
    pam_checker i_pam_checker (.clock(clock), .nrst(nrst), .io_valid(lnk.io_valid),
        .io_addr(lnk.io_addr), .io_on_pci_ide(lnk.io_on_pci_ide),
        .primary_ide_dma_ack_n(lnk.primary_ide_dma_ack_n),
        .secondary_ide_dma_ack_n(lnk.secondary_ide_dma_ack_n),
        .isa_dma_ack_channel_n(lnk.isa_dma_ack_channel_n), .gpi(lnk.gpi),
        .idle_reload(lnk.idle_reload), .trap_pulse(lnk.trap_pulse),
        .timer_reload(lnk.timer_reload), .forward_isa(lnk.forward_isa),
        .count_group_sel(lnk.count_group_sel), .trap_sts(lnk.trap_sts));

    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [5:0] seen, input logic [5:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [2:0] exp_tmr(input logic [5:0] m);
        return {|(m & brst_en & ~sel_fast & CAP_S), |(m & brst_en & sel_fast & CAP_F),
            |(m & glb_en)};
    endfunction

    task automatic chk_ev(input logic [5:0] m, input logic io);
        chk("idle_reload", lnk.idle_reload, m & idle_en);
        chk("timer_reload", 6'(lnk.timer_reload), 6'(exp_tmr(m)));
        all_rl |= exp_tmr(m);
        if (io) begin
            chk("trap_pulse", lnk.trap_pulse, m & trap_en);
            chk("forward_isa", 6'(lnk.forward_isa), 6'(|(m & fwd_en & range_en)));
        end
    endtask

    // Monitors 4 and 5 have no drive select, so only the IDE bits are gated by drv.
    task automatic io(input logic [15:0] a, input logic ide, input logic [5:0] dec);
        logic [5:0] m;
        m = ide ? 6'h00 : dec & range_en & (drv | 6'h30);
        @(posedge clock);
        cyc_valid <= 1'b1;
        cyc_addr <= a;
        cyc_to_pci_ide <= ide;
        @(posedge clock);
        cyc_valid <= 1'b0;
        @(posedge clock);
        #1;
        chk_ev(m, 1'b1);
        sticky |= m & trap_en;
        all_tr |= m & trap_en;
    endtask

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        conclude();
    end

    initial begin
        failures = 0;
        n_checks = 0;
        all_tr = 6'h00;
        all_rl = 3'h0;
        clk_en = 1'b1;
        nrst = 1'b0;
        cyc_valid = 1'b0;
        cyc_addr = 16'h0;
        cyc_to_pci_ide = 1'b0;
        sb = {1'b1, 1'b1, 8'hff, 22'h002040};
        {range_en, dack_en, gpi_en, idle_en, glb_en, brst_en} = {6{6'h3f}};
        {sel_fast, trap_en, fwd_en, drv, sts_clr} = {5{6'h00}};
        pol = 6'h2a;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            @(posedge clock);
            drv <= p[0] ? 6'h0a : 6'h05;
            sel_fast <= p[1] ? 6'h3f : 6'h00;
            brst_en <= p[1] ? 6'h3f : 6'h35;
            trap_en <= p[1] ? 6'h3f : 6'h2a;
            fwd_en <= p[0] ? 6'h3f : 6'h30;
            idle_en <= p[1] ? 6'h3f : 6'h33;
            glb_en <= p[0] ? 6'h3f : 6'h1e;
            range_en <= (p == 3) ? 6'h2d : 6'h3f;
            sts_clr <= 6'h3f;
            @(posedge clock);
            sts_clr <= 6'h00;
            sticky = 6'h00;
            @(posedge clock);
            #1;
            chk("trap_sts", lnk.trap_sts, 6'h00);
            for (int i = 0; i < 49; i++) begin
                io(ADDRS[i], 1'b0, DECS[i]);
                if (DECS[i][3:0] != 4'h0) begin
                    io(ADDRS[i], 1'b1, DECS[i]);
                end
            end
            chk("trap_sts", lnk.trap_sts, sticky);
        end
        chk("trap_seen", trap_seen, all_tr);
        @(posedge clock);
        drv <= 6'h0f;
        idle_en <= 6'h3f;
        glb_en <= 6'h3f;
        for (int i = 0; i < 11; i++) begin
            @(posedge clock);
            sb[SB_BIT[i]] <= ~sb[SB_BIT[i]];
            repeat (4) @(posedge clock);
            #1;
            chk_ev(SB_DEC[i], 1'b0);
            @(posedge clock);
            #1;
            chk_ev(6'h00, 1'b0);
            @(posedge clock);
            sb[SB_BIT[i]] <= ~sb[SB_BIT[i]];
            repeat (6) @(posedge clock);
        end
        // With the enable low a hitting cycle must leave every output untouched.
        @(posedge clock);
        clk_en <= 1'b0;
        io(16'h01f0, 1'b0, 6'h00);
        @(posedge clock);
        clk_en <= 1'b1;
        chk("reload_seen", 6'(reload_seen), 6'(all_rl));
        conclude();
    end
endmodule
